// ---- sivw_chan.v ----
// One channel: control register, pending flags and wait/ready handshake
`timescale 1ns/1ns
`include "sivw_regs.vh"
module sivw_chan (
	input  wire       clk_sys,     // System clock
	input  wire       rstn,        // Async reset, active low
	input  wire       ctrlWr,      // Write of control register
	input  wire [7:0] wrData,      // Write data
	input  wire       cmdRstExt,   // Re-arm external/status latch
	input  wire       cmdRstTx,    // Reset transmit interrupt pending
	input  wire       chanRst,     // Channel reset pulse
	input  wire [2:0] extIn,       // Synchronised cd, cts, align inputs
	input  wire       brkIn,       // Synchronised break/abort state
	input  wire       eomSet,      // Underrun/end-of-message latch set
	input  wire       txEmpty,     // Transmit buffer empty
	input  wire       txLoad,      // Character loaded to transmit buffer
	input  wire       crcDone,     // CRC transmission complete
	input  wire       rxFull,      // Receive buffer full
	input  wire       rxChar,      // Character received pulse
	input  wire       rxFirst,     // First character of message
	input  wire       parErr,      // Parity error with character
	input  wire       otherErr,    // Overrun, framing or end of frame
	input  wire       dataSel,     // This channel's data port selected
	input  wire       otherSel,    // Opposite channel addressed
	input  wire       ioAct,       // Strobe and select both active
	input  wire       ackDone,     // Acknowledge of this channel source
	input  wire [1:0] ackSrc,      // Source being acknowledged
	output reg  [7:0] ctrl,        // Control register
	output reg  [3:0] pend,        // Pending: spc, rx, ext, tx
	output reg  [2:0] extLatch,    // Latched external status
	output reg        wrOut,       // Handshake output level
	output reg        wrOe         // Handshake output enable
);
	reg  [2:0] extPrev;
	reg        brkPrev;
	reg        extArmed;
	reg        txArmed;
	reg        txEmptyD;
	wire       extChg = (extIn != extPrev) || (brkIn != brkPrev) || eomSet;
	wire       rxMode1 = ctrl[`SIVW_BIT_RXM1];
	wire       rxMode0 = ctrl[`SIVW_BIT_RXM0];
	wire       rxOn = rxMode1 | rxMode0;
	// R6 R7 parity only special in mode 10
	wire       special = rxChar & (otherErr | (parErr & rxMode1 & ~rxMode0));
	// R7 first only or every character
	wire       rxHit = rxChar & ~special & rxOn
		& (rxMode1 | rxFirst);
	wire       txRise = txEmpty & ~txEmptyD;
	wire       wrAct;
	wire       wrTrack;

	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctrl <= `SIVW_CTRL_RST;
			pend <= 4'h0;
			extLatch <= 3'h0;
			extPrev <= 3'h0;
			brkPrev <= 1'b0;
			extArmed <= 1'b1;
			txArmed <= 1'b1;
			txEmptyD <= 1'b1;
		end else if (chanRst) begin
			ctrl <= `SIVW_CTRL_RST;
			pend <= 4'h0;
			extArmed <= 1'b1;
			txArmed <= 1'b1;
			extPrev <= extIn;
			brkPrev <= brkIn;
			txEmptyD <= txEmpty;
		end else begin
			if (ctrlWr)
				ctrl <= wrData;
			extPrev <= extIn;
			brkPrev <= brkIn;
			txEmptyD <= txEmpty;
			// R23 latch until re-armed
			if (extArmed && extChg && ctrl[`SIVW_BIT_EXTEN]) begin
				extLatch <= extIn;
				extArmed <= 1'b0;
			end else if (cmdRstExt)
				extArmed <= 1'b1;
			// R22 suppress until next load
			if (txLoad || crcDone)
				txArmed <= 1'b1;
			else if (cmdRstTx)
				txArmed <= 1'b0;
			// R2 transmit empty interrupt
			if (txRise && txArmed && ctrl[`SIVW_BIT_TXEN])
				pend[0] <= 1'b1;
			else if ((ackDone && ackSrc == `SIVW_SRC_TX) || cmdRstTx)
				pend[0] <= 1'b0;
			// R1 external status interrupt
			if (extArmed && extChg && ctrl[`SIVW_BIT_EXTEN])
				pend[1] <= 1'b1;
			else if (ackDone && ackSrc == `SIVW_SRC_EXT)
				pend[1] <= 1'b0;
			if (rxHit)
				pend[2] <= 1'b1;
			else if (ackDone && ackSrc == `SIVW_SRC_RX)
				pend[2] <= 1'b0;
			// R8 special in every nonzero mode
			if (special && rxOn)
				pend[3] <= 1'b1;
			else if (ackDone && ackSrc == `SIVW_SRC_SPC)
				pend[3] <= 1'b0;
		end
	end

	// R13 R14 R15 buffer being tracked
	assign wrTrack = ctrl[`SIVW_BIT_WRRX] ? rxFull : txEmpty;
	// R19 wait also when other channel addressed
	assign wrAct = ctrl[`SIVW_BIT_WRRX] ? (~rxFull & (dataSel | otherSel))
		: (~txEmpty & (dataSel | otherSel));

	// R16 ready asserts on rising edge
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wrOut <= 1'b1;
			wrOe <= 1'b0;
		end else if (!ctrl[`SIVW_BIT_WREN]) begin
			// R9 R21 disabled: high or released
			wrOut <= 1'b1;
			wrOe <= ctrl[`SIVW_BIT_WRFUNC];
		end else if (ctrl[`SIVW_BIT_WRFUNC]) begin
			// R12 R17 ready low, released on access
			wrOut <= ~(wrTrack & ~ioAct);
			wrOe <= 1'b1;
		end else begin
			// R10 R11 wait pulls low or floats
			wrOut <= 1'b0;
			wrOe <= wrAct & ioAct;
		end
	end
endmodule // sivw_chan

// ---- sivw_host.sv ----
// Host CPU and DMA model on the parallel bus
`timescale 1ns/1ns
module sivw_host (
	input  wire       clk_sys,   // Clock
	input  wire       dmaOn,     // DMA engine enabled
	input  wire       readyLine, // Channel A handshake line
	output reg        ioReq_n,   // I/O request, active low
	output reg        cs_n,      // Chip select, active low
	output reg        chB,       // Channel B select
	output reg        ctrlSel,   // Control or data
	output reg        rd_n,      // Read strobe, active low
	output reg  [7:0] dBus       // Write data
);
	initial begin
		ioReq_n = 1'b1;
		cs_n = 1'b1;
		chB = 1'b0;
		ctrlSel = 1'b0;
		rd_n = 1'b1;
		dBus = 8'hA5;
	end
	task busWr(input b, input c, input [7:0] d);
		begin
			@(posedge clk_sys);
			ioReq_n <= 1'b0;
			cs_n <= 1'b0;
			chB <= b;
			ctrlSel <= c;
			dBus <= d;
			repeat (4) @(posedge clk_sys);
			ioReq_n <= 1'b1;
			cs_n <= 1'b1;
			// Released bus shows no stale byte
			dBus <= ~d;
			repeat (2) @(posedge clk_sys);
		end
	endtask
	always @(posedge clk_sys)
		if (dmaOn && readyLine === 1'b0)
			busWr(1'b0, 1'b0, 8'h5A);
endmodule // sivw_host

// ---- sivw_props.sv ----
// Checker of vector and handshake outputs of the interrupt block
`timescale 1ns/1ns
module sivw_props (
	input wire       clk_sys,             // Clock
	input wire       rstn,                // Reset, active low
	input wire       io_request_strobe_n, // I/O request
	input wire       chipSel_n,           // Chip select
	input wire       intAck,              // Acknowledge
	input wire [7:0] dOut,                // Vector out
	input wire       dOe,                 // Vector drive
	input wire       intReq_n,            // Request
	input wire [1:0] waitReadyOe          // Handshake drive
);
	reg cfgSeen;
	// Early set keeps the reset-state checks conservative
	always @(posedge clk_sys or negedge rstn)
		if (!rstn)
			cfgSeen <= 1'b0;
		else if (!io_request_strobe_n && !chipSel_n)
			cfgSeen <= 1'b1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_ack_drive_copy: assert property (dOe == $past(intAck))
		else $error("vector drive does not follow acknowledge");
	a_ack_drop_release: assert property ($fell(intAck) |=> !dOe)
		else $error("vector drive held after acknowledge");
	a_ack_held_drive: assert property (intAck [*2] |-> dOe)
		else $error("vector not driven during acknowledge");
	a_idle_float_a: assert property (!cfgSeen |-> !waitReadyOe[0])
		else $error("channel A handshake driven before setup");
	a_idle_float_b: assert property (!cfgSeen |-> !waitReadyOe[1])
		else $error("channel B handshake driven before setup");
	a_idle_no_request: assert property (!cfgSeen |-> intReq_n)
		else $error("request raised with interrupts disabled");
	a_idle_vector_zero: assert property (!cfgSeen && dOe |-> dOut == 8'h00)
		else $error("vector differs from cleared base");
	a_idle_vector_hold: assert property (!cfgSeen && dOe && $past(dOe)
		|-> $stable(dOut))
		else $error("fixed vector changed during acknowledge");
	a_ack_vector_hold: assert property (dOe && $past(dOe)
		|-> $stable(dOut))
		else $error("vector changed during acknowledge");
endmodule // sivw_props
bind sivw_top sivw_props u_props (.clk_sys(clk_sys), .rstn(rstn),
	.io_request_strobe_n(io_request_strobe_n), .chipSel_n(chipSel_n),
	.intAck(intAck), .dOut(dOut), .dOe(dOe), .intReq_n(intReq_n),
	.waitReadyOe(waitReadyOe));

// ---- sivw_regs.vh ----
// Register field positions, commands and reset values for the interrupt block
`ifndef SIVW_REGS_VH
`define SIVW_REGS_VH
`define SIVW_PTR_CTRL      3'h1
`define SIVW_PTR_VECT      3'h2
`define SIVW_CMD_RST_EXT   3'h2
`define SIVW_CMD_CH_RST    3'h3
`define SIVW_CMD_RST_TXINT 3'h5
`define SIVW_BIT_EXTEN     0
`define SIVW_BIT_TXEN      1
`define SIVW_BIT_SAV       2
`define SIVW_BIT_RXM0      3
`define SIVW_BIT_RXM1      4
`define SIVW_BIT_WRRX      5
`define SIVW_BIT_WRFUNC    6
`define SIVW_BIT_WREN      7
`define SIVW_CTRL_RST      8'h00
`define SIVW_VECT_RST      8'h00
`define SIVW_SRC_TX        2'h0
`define SIVW_SRC_EXT       2'h1
`define SIVW_SRC_RX        2'h2
`define SIVW_SRC_SPC       2'h3
`endif

// ---- sivw_top.v ----
// Two-channel interrupt, vector and wait/ready control top
// Behaviour
// R1 - External status changes interrupt when enabled
// R2 - Transmit buffer empty interrupts when enabled
// R3 - Status-affects-vector honoured only in channel B
// R4 - Fixed vector unless status affects vector
// R5 - Bits 3..1 encode channel and source
// R6 - Parity, overrun, framing, end-of-frame are special
// R7 - Receive mode field selects interrupt behaviour
// R8 - Special condition interrupts in nonzero modes
// R9 - Handshake follows buffer only when enabled
// R10 - Function bit selects wait or ready
// R11 - Wait floats inactive, pulls low active
// R12 - Ready goes low when ready to transfer
// R13 - Track receive or transmit buffer, never both
// R14 - Transmit tracking ready and wait levels
// R15 - Receive tracking ready and wait levels
// R16 - Ready on rising, wait released on falling (here wait also releases on a rising clock edge)
// R17 - Ready asserts unselected, released on access
// R18 - DMA answers ready with one byte transfer
// R19 - Wait active when opposite channel addressed
// R20 - One vector register, bits 3..1 conditional
// R21 - Disabled handshake high or floating
// R22 - Reset transmit pending suppresses until load
// R23 - External latch re-armed by reset command
`timescale 1ns/1ns
`include "sivw_regs.vh"
module sivw_top (
	input  wire       clk_sys,       // System clock 25 MHz
	input  wire       rstn,          // Async reset, active low
	input  wire       io_request_strobe_n, // I/O request, active low
	input  wire       chipSel_n,     // Chip select, active low
	input  wire       chanSelB,      // 1 selects channel B
	input  wire       ctrlSel,       // 1 control, 0 data
	input  wire       rdStrobe_n,    // Read strobe, active low
	input  wire       intAck,        // Interrupt acknowledge pulse
	input  wire [7:0] dIn,           // Data bus input
	input  wire [2:0] extA,          // A cd, cts, align pins
	input  wire [2:0] extB,          // B cd, cts, align pins
	input  wire [1:0] brk,           // Break/abort per channel
	input  wire [1:0] eomSet,        // Underrun latch set per channel
	input  wire [1:0] txEmpty,       // Transmit buffer empty
	input  wire [1:0] txLoad,        // Transmit buffer loaded
	input  wire [1:0] crcDone,       // CRC sent
	input  wire [1:0] rxFull,        // Receive buffer full
	input  wire [1:0] rxChar,        // Character received
	input  wire [1:0] rxFirst,       // First character of message
	input  wire [1:0] parErr,        // Parity error
	input  wire [1:0] otherErr,      // Overrun, framing, end of frame
	output reg  [7:0] dOut,          // Data out (vector)
	output reg        dOe,           // Data bus drive enable
	output reg        intReq_n,      // Interrupt request, active low
	output reg  [1:0] waitReadyOut,  // Handshake output level
	output reg  [1:0] waitReadyOe    // Handshake output enable
);
	reg  [2:0] ptr [0:1];
	reg  [7:0] vectBase;
	reg        strbS1, strbS2, strbPrev;
	reg  [7:0] exS1, exS2;
	wire       ioAct = ~strbS2 & ~chipSel_n;
	wire       wrPulse = strbPrev & ~strbS2 & ~chipSel_n & rdStrobe_n;
	wire       chB = chanSelB;
	wire [2:0] curPtr = ptr[chB];
	wire [7:0] ctrlA, ctrlB;
	wire [3:0] pendA, pendB;
	wire [1:0] wrO, wrE;
	wire       isCmd = wrPulse & ctrlSel & (curPtr == 3'h0);
	wire [2:0] cmd = dIn[5:3];
	reg        ackChan;
	reg  [1:0] ackS;
	reg        ackDo;
	reg        ackPrev;
	reg        ackAny;
	wire [1:0] srcSel;
	wire       ackA = ackDo & ~ackChan;
	wire       ackB = ackDo & ackChan;

	function [1:0] prio;
		input [3:0] p;
		begin
			if (p[3])
				prio = `SIVW_SRC_SPC;
			else if (p[2])
				prio = `SIVW_SRC_RX;
			else if (p[0])
				prio = `SIVW_SRC_TX;
			else
				prio = `SIVW_SRC_EXT;
		end
	endfunction

	assign srcSel = |pendA ? prio(pendA) : prio(pendB);

	// Strobe and external status pins pass two flops before any logic
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			strbS1 <= 1'b1;
			strbS2 <= 1'b1;
			strbPrev <= 1'b1;
			exS1 <= 8'h00;
			exS2 <= 8'h00;
		end else begin
			strbS1 <= io_request_strobe_n;
			strbS2 <= strbS1;
			strbPrev <= strbS2;
			exS1 <= {extB, extA, brk};
			exS2 <= exS1;
		end
	end

	// Register pointer and vector base
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ptr[0] <= 3'h0;
			ptr[1] <= 3'h0;
			vectBase <= `SIVW_VECT_RST;
		end else if (wrPulse && ctrlSel) begin
			if (curPtr == 3'h0)
				ptr[chB] <= (cmd == `SIVW_CMD_CH_RST) ? 3'h0 : dIn[2:0];
			else
				ptr[chB] <= 3'h0;
			// R20 single vector held in channel B
			if (chB && curPtr == `SIVW_PTR_VECT)
				vectBase <= dIn;
		end
	end

	sivw_chan u_chA (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.ctrlWr    (wrPulse & ctrlSel & ~chB & (curPtr == `SIVW_PTR_CTRL)),
		.wrData    (dIn),
		.cmdRstExt (isCmd & ~chB & (cmd == `SIVW_CMD_RST_EXT)),
		.cmdRstTx  (isCmd & ~chB & (cmd == `SIVW_CMD_RST_TXINT)),
		.chanRst   (isCmd & ~chB & (cmd == `SIVW_CMD_CH_RST)),
		.extIn     (exS2[4:2]),
		.brkIn     (exS2[0]),
		.eomSet    (eomSet[0]),
		.txEmpty   (txEmpty[0]),
		.txLoad    (txLoad[0]),
		.crcDone   (crcDone[0]),
		.rxFull    (rxFull[0]),
		.rxChar    (rxChar[0]),
		.rxFirst   (rxFirst[0]),
		.parErr    (parErr[0]),
		.otherErr  (otherErr[0]),
		.dataSel   (~ctrlSel & ~chB),
		.otherSel  (chB),
		.ioAct     (ioAct),
		.ackDone   (ackA),
		.ackSrc    (ackS),
		.ctrl      (ctrlA),
		.pend      (pendA),
		.extLatch  (),
		.wrOut     (wrO[0]),
		.wrOe      (wrE[0])
	);

	sivw_chan u_chB (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.ctrlWr    (wrPulse & ctrlSel & chB & (curPtr == `SIVW_PTR_CTRL)),
		.wrData    (dIn),
		.cmdRstExt (isCmd & chB & (cmd == `SIVW_CMD_RST_EXT)),
		.cmdRstTx  (isCmd & chB & (cmd == `SIVW_CMD_RST_TXINT)),
		.chanRst   (isCmd & chB & (cmd == `SIVW_CMD_CH_RST)),
		.extIn     (exS2[7:5]),
		.brkIn     (exS2[1]),
		.eomSet    (eomSet[1]),
		.txEmpty   (txEmpty[1]),
		.txLoad    (txLoad[1]),
		.crcDone   (crcDone[1]),
		.rxFull    (rxFull[1]),
		.rxChar    (rxChar[1]),
		.rxFirst   (rxFirst[1]),
		.parErr    (parErr[1]),
		.otherErr  (otherErr[1]),
		.dataSel   (~ctrlSel & chB),
		.otherSel  (~chB),
		.ioAct     (ioAct),
		.ackDone   (ackB),
		.ackSrc    (ackS),
		.ctrl      (ctrlB),
		.pend      (pendB),
		.extLatch  (),
		.wrOut     (wrO[1]),
		.wrOe      (wrE[1])
	);

	// Acknowledge: channel A outranks B; vector is built here
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dOut <= 8'h00;
			dOe <= 1'b0;
			intReq_n <= 1'b1;
			ackChan <= 1'b0;
			ackS <= 2'h0;
			ackDo <= 1'b0;
			ackPrev <= 1'b0;
			ackAny <= 1'b0;
			waitReadyOut <= 2'h3;
			waitReadyOe <= 2'h0;
		end else begin
			intReq_n <= ~(|pendA | |pendB);
			waitReadyOut <= wrO;
			waitReadyOe <= wrE;
			dOe <= intAck;
			ackPrev <= intAck;
			// One clear as acknowledge ends, so a long one loses nothing
			ackDo <= ackPrev & ~intAck & ackAny;
			// Source and vector freeze while acknowledge is under way
			if (!intAck && !ackPrev) begin
				ackAny <= |pendA | |pendB;
				ackChan <= ~|pendA;
				ackS <= srcSel;
				// R3 R4 R5 only channel B bit modifies
				if (ctrlB[`SIVW_BIT_SAV] && (|pendA || |pendB))
					dOut <= {vectBase[7:4], |pendA, srcSel,
						vectBase[0]};
				else
					dOut <= vectBase;
			end
		end
	end
endmodule // sivw_top

// ---- testbench.sv ----
// Self-checking bench for the two-channel interrupt block
`timescale 1ns/1ns
`include "sivw_regs.vh"
module testbench;
	reg        clk_sys, rstn, intAck, dmaOn;
	reg  [2:0] extA, extB;
	reg  [1:0] txEmpty, rxFull, rxChar, parErr, zero2;
	reg  [1:0] brk, txLd, rxFst, oErr;
	wire       ioReq_n, cs_n, chB, ctrlSel, rd_n, dOe, intReq_n;
	wire [7:0] dBus, dOut;
	wire [1:0] wrOut, wrOe;
	wire [1:0] wrLine = ~wrOe | wrOut;
	integer    n_fail, cmp_count, i, k, t;
	reg  [31:0] rnd;
	reg  [7:0] base;
	reg [11:0] ent;
	localparam [95:0] HS = 96'hC0A_C03_E06_E03_40B_008_808_A04;
	sivw_host host (.clk_sys(clk_sys), .dmaOn(dmaOn), .readyLine(wrLine[0]),
		.ioReq_n(ioReq_n), .cs_n(cs_n), .chB(chB), .ctrlSel(ctrlSel),
		.rd_n(rd_n), .dBus(dBus));
	sivw_top dut (.clk_sys(clk_sys), .rstn(rstn),
		.io_request_strobe_n(ioReq_n), .chipSel_n(cs_n), .chanSelB(chB),
		.ctrlSel(ctrlSel), .rdStrobe_n(rd_n), .intAck(intAck), .dIn(dBus),
		.extA(extA), .extB(extB), .brk(brk), .eomSet(zero2),
		.txEmpty(txEmpty), .txLoad(txLd), .crcDone(zero2), .rxFull(rxFull),
		.rxChar(rxChar), .rxFirst(rxFst), .parErr(parErr),
		.otherErr(oErr), .dOut(dOut), .dOe(dOe), .intReq_n(intReq_n),
		.waitReadyOut(wrOut), .waitReadyOe(wrOe));
	function [31:0] lfsr(input [31:0] x);
		lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function [7:0] vexp(input [7:0] b, input sav, input ch, input [1:0] s);
		vexp = sav ? {b[7:4], ~ch, s, b[0]} : b;
	endfunction
	task chk(input string what, input [7:0] seen, input [7:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
			end
		end
	endtask
	task final_report;
		begin
			if (n_fail == 0 && cmp_count > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task wrReg(input b, input [2:0] p, input [7:0] v);
		begin
			host.busWr(b, 1'b1, {5'h00, p});
			host.busWr(b, 1'b1, v);
		end
	endtask
	task waitReq(input lvl);
		begin
			t = 0;
			while (intReq_n !== lvl && t < 40) begin
				@(posedge clk_sys);
				t = t + 1;
			end
			if (t == 40) begin
				n_fail = n_fail + 1;
				final_report;
			end
		end
	endtask
	task ackChk(input [7:0] exp);
		begin
			@(posedge clk_sys);
			intAck <= 1'b1;
			repeat (3) @(posedge clk_sys);
			@(negedge clk_sys);
			chk("vector", dOut, exp);
			@(posedge clk_sys);
			intAck <= 1'b0;
			waitReq(1'b1);
		end
	endtask
	task fire(input ch, input [1:0] s);
		begin
			@(posedge clk_sys);
			case (s)
			2'h0: txEmpty[ch] <= 1'b1;
			2'h1: if (ch) extB[0] <= ~extB[0]; else extA[0] <= ~extA[0];
			default: begin
				rxFull[ch] <= 1'b1;
				rxChar[ch] <= 1'b1;
				parErr[ch] <= s[0];
			end
			endcase
			@(posedge clk_sys);
			rxChar <= 2'b00;
			waitReq(1'b0);
		end
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		{rstn, intAck, dmaOn, extA, extB} = 9'h000;
		{txEmpty, rxFull, rxChar, parErr, zero2} = 10'h000;
		{brk, txLd, rxFst, oErr} = 8'h00;
		n_fail = 0;
		cmp_count = 0;
		rnd = 32'h1FA5;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("handshake drive", {6'h00, wrOe}, 8'h00);
		ackChk(8'h00);
		for (k = 0; k < 2; k = k + 1) begin
			rnd = lfsr(rnd);
			base = rnd[7:0];
			wrReg(1'b1, `SIVW_PTR_VECT, base);
			wrReg(1'b0, `SIVW_PTR_VECT, ~base);
			wrReg(1'b0, `SIVW_PTR_CTRL, k ? 8'h13 : 8'h17);
			wrReg(1'b1, `SIVW_PTR_CTRL, k ? 8'h17 : 8'h13);
			for (i = 0; i < 8; i = i + 1) begin
				fire(i[2], i[1:0]);
				ackChk(vexp(base, k[0], i[2], i[1:0]));
				{txEmpty, rxFull, parErr} <= 6'h00;
				host.busWr(i[2], 1'b1, {2'b00, `SIVW_CMD_RST_EXT, 3'h0});
			end
		end
		wrReg(1'b1, `SIVW_PTR_CTRL, 8'h1F);
		fire(1'b1, 2'h3);
		ackChk(vexp(base, 1'b1, 1'b1, `SIVW_SRC_RX));
		{rxFull, parErr} <= 4'h0;
		for (i = 0; i < 16; i = i + 1) begin
			ent = HS[95 - 12 * i[2:0] -: 12];
			wrReg(i[3], `SIVW_PTR_CTRL, ent[11:4]);
			txEmpty[i[3]] <= ent[3];
			rxFull[i[3]] <= ent[2];
			repeat (4) @(posedge clk_sys);
			@(negedge clk_sys);
			chk("handshake", {wrOe[i[3]], wrOe[i[3]] & wrOut[i[3]]},
				ent[1:0]);
		end
		wrReg(1'b0, `SIVW_PTR_CTRL, 8'hC0);
		txEmpty <= 2'b01;
		dmaOn <= 1'b1;
		t = 0;
		while (wrLine[0] !== 1'b0 && t < 30) begin
			@(posedge clk_sys);
			t = t + 1;
		end
		while (wrLine[0] !== 1'b1 && t < 30) begin
			@(posedge clk_sys);
			t = t + 1;
		end
		chk("ready release", {7'h00, t < 30}, 8'h01);
		dmaOn <= 1'b0;
		repeat (10) @(posedge clk_sys);
		// Wait pulls low mid-access, in the other channel too
		wrReg(1'b0, `SIVW_PTR_CTRL, 8'h80);
		wrReg(1'b1, `SIVW_PTR_CTRL, 8'h80);
		txEmpty <= 2'b00;
		fork
			host.busWr(1'b0, 1'b0, 8'h3C);
			begin
				repeat (5) @(posedge clk_sys);
				@(negedge clk_sys);
				chk("wait active", {4'h0, wrOe, wrOut}, 8'h0C);
			end
		join
		wrReg(1'b1, `SIVW_PTR_CTRL, 8'h04);
		wrReg(1'b0, `SIVW_PTR_CTRL, 8'h0B);
		host.busWr(1'b0, 1'b1, {2'b00, `SIVW_CMD_RST_TXINT, 3'h0});
		txEmpty <= 2'b01;
		repeat (4) @(posedge clk_sys);
		txEmpty <= 2'b00;
		txLd <= 2'b01;
		@(negedge clk_sys);
		chk("tx suppressed", {7'h00, intReq_n}, 8'h01);
		@(posedge clk_sys);
		txLd <= 2'b00;
		fire(1'b0, `SIVW_SRC_TX);
		ackChk(vexp(base, 1'b1, 1'b0, `SIVW_SRC_TX));
		@(posedge clk_sys);
		rxChar <= 2'b01;
		@(posedge clk_sys);
		rxChar <= 2'b00;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("rx not first", {7'h00, intReq_n}, 8'h01);
		@(posedge clk_sys);
		rxFst <= 2'b01;
		fire(1'b0, `SIVW_SRC_RX);
		ackChk(vexp(base, 1'b1, 1'b0, `SIVW_SRC_RX));
		rxFst <= 2'b00;
		oErr <= 2'b01;
		fire(1'b0, `SIVW_SRC_RX);
		ackChk(vexp(base, 1'b1, 1'b0, `SIVW_SRC_SPC));
		oErr <= 2'b00;
		brk <= 2'b01;
		waitReq(1'b0);
		ackChk(vexp(base, 1'b1, 1'b0, `SIVW_SRC_EXT));
		brk <= 2'b00;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		chk("ext latched", {7'h00, intReq_n}, 8'h01);
		@(posedge clk_sys);
		txEmpty <= 2'b00;
		fire(1'b0, `SIVW_SRC_TX);
		host.busWr(1'b0, 1'b1, {2'b00, `SIVW_CMD_CH_RST, 3'h0});
		waitReq(1'b1);
		chk("channel reset", {7'h00, intReq_n}, 8'h01);
		final_report;
	end
endmodule // testbench
